// ==== lcc_cell.sv ====
// One logic cell: lookup table, carry and cascade logic, flip-flop
`timescale 1ns/10ps
module lcc_cell (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Configuration and data inputs
    input wire logic [31:0] cfg,
    input wire logic [3:0] din,
    // Chains
    input wire logic cin,
    input wire logic casc_in,
    output logic cout,
    output logic casc_out,
    // Control source candidates
    input wire logic [3:0] clk_src,
    input wire logic [3:0] clr_src,
    input wire logic [3:0] pre_src,
    // Results
    output logic lut_out,
    output logic q,
    output logic local_out,
    output logic row_out
);

    logic [15:0] mask;
    logic arith;
    logic lut_raw;
    logic comb;
    logic clk_now;
    logic clk_prev_r;
    logic tick;
    logic clr;
    logic pre;
    logic q_r;
    logic q_nxt;
    logic reg_path;
    lcc_pkg::lcc_ff_e mode;

    // ------------------------------------------------------------
    // Lookup table and chains
    // ------------------------------------------------------------
    // Arithmetic mode splits the table: low half sum, high half carry
    assign mask = cfg[15:0];
    assign arith = cfg[lcc_pkg::CFG_ARITH];
    assign lut_raw = arith ? mask[{1'b0, cin, din[1:0]}]
                           : mask[din];
    assign cout = arith ? mask[{1'b1, cin, din[1:0]}] : cin;
    assign comb = !cfg[lcc_pkg::CFG_CASC_EN] ? lut_raw :
                  cfg[lcc_pkg::CFG_CASC_OR] ? (lut_raw | casc_in) :
                  (lut_raw & casc_in);
    assign casc_out = comb;
    assign lut_out = comb;

    // ------------------------------------------------------------
    // Control source selection
    // ------------------------------------------------------------
    // Clock source acts as an edge enable on the one system clock
    assign clk_now = lcc_pkg::lcc_pick(cfg[lcc_pkg::CFG_CLK_LSB +: 2],
                                       clk_src);
    assign clr = lcc_pkg::lcc_pick(cfg[lcc_pkg::CFG_CLR_LSB +: 2],
                                   clr_src);
    assign pre = lcc_pkg::lcc_pick(cfg[lcc_pkg::CFG_PRE_LSB +: 2],
                                   pre_src);
    assign tick = clk_now & ~clk_prev_r;
    assign mode = lcc_pkg::lcc_ff_e'(cfg[lcc_pkg::CFG_FF_LSB +: 2]);

    // Previous level of the selected clock source
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_prev_r <= 1'b0;
        end else begin
            clk_prev_r <= clk_now;
        end
    end

    // Next state per flip-flop type; din[3] is K or R
    always_comb begin
        case (mode)
            lcc_pkg::LCC_FF_T: q_nxt = q_r ^ comb;
            lcc_pkg::LCC_FF_JK: q_nxt = (comb & ~q_r) | (~din[3] & q_r);
            lcc_pkg::LCC_FF_SR: q_nxt = comb | (~din[3] & q_r);
            default: q_nxt = comb;
        endcase
    end

    // Storage element; clear beats preset beats clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_r <= 1'b0;
        end else if (clr) begin
            q_r <= 1'b0;
        end else if (pre) begin
            q_r <= 1'b1;
        end else if (tick) begin
            q_r <= q_nxt;
        end
    end

    // ------------------------------------------------------------
    // Output selection
    // ------------------------------------------------------------
    assign q = q_r;
    assign reg_path = cfg[lcc_pkg::CFG_BYPASS] ? comb : q_r;
    assign local_out = cfg[lcc_pkg::CFG_LOC_SEL] ? reg_path : comb;
    assign row_out = cfg[lcc_pkg::CFG_ROW_SEL] ? reg_path : comb;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_clear_wins: assert property (clr |=> !q_r)
        else $error("clear did not empty the cell flip-flop");
    a_preset_sets: assert property ((pre && !clr) |=> q_r)
        else $error("preset did not set the cell flip-flop");
    a_hold_idle: assert property (!tick && !clr && !pre
        |=> $stable(q_r))
        else $error("flip-flop moved without a clock edge");
    a_d_capture: assert property ((tick && !clr && !pre &&
        mode == lcc_pkg::LCC_FF_D) |=> q_r == $past(comb))
        else $error("D flip-flop did not capture the table output");
    a_toggle_flip: assert property ((tick && !clr && !pre && comb &&
        mode == lcc_pkg::LCC_FF_T) |=> q_r != $past(q_r))
        else $error("T flip-flop did not toggle");
    c_cell_tick: cover property (tick && !clr && !pre);

endmodule : lcc_cell

// ==== lcc_fabric.sv ====
// Routing fabric model that drives the general-purpose pins
`timescale 1ns/10ps
module lcc_fabric (
    // Clock
    input wire logic aclk,
    // Pins toward the cell row
    output logic [1:0] gp_in
);
    // Pins wander; chains stay on the timed paths only
    initial gp_in = 2'h0;
    always @(posedge aclk) gp_in <= 2'($urandom);
endmodule : lcc_fabric

// ==== lcc_pkg.sv ====
// Shared constants and types for the logic cell row with carry chain
package lcc_pkg;

    // ------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------
    localparam int CELLS_PER_CLU = 8;
    localparam int NUM_CLU = 6;
    localparam int NUM_CELLS = 48;
    // Embedded memory block sits right after this cluster index
    localparam int MEM_AFTER = 2;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_SEL = 8'h00;
    localparam logic [7:0] ADDR_CFG = 8'h04;
    localparam logic [7:0] ADDR_IN = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0C;
    localparam logic [7:0] ADDR_GLB = 8'h10;
    localparam logic [7:0] ADDR_ROW_LO = 8'h14;
    localparam logic [7:0] ADDR_ROW_HI = 8'h18;
    localparam logic [7:0] ADDR_LOC_LO = 8'h1C;
    localparam logic [7:0] ADDR_LOC_HI = 8'h20;
    localparam logic [7:0] ADDR_CHAIN = 8'h24;

    // ------------------------------------------------------------
    // Cell configuration word fields
    // ------------------------------------------------------------
    localparam int CFG_FF_LSB = 16;
    localparam int CFG_BYPASS = 18;
    localparam int CFG_LOC_SEL = 19;
    localparam int CFG_ROW_SEL = 20;
    localparam int CFG_ARITH = 21;
    localparam int CFG_CLK_LSB = 22;
    localparam int CFG_CLR_LSB = 24;
    localparam int CFG_PRE_LSB = 26;
    localparam int CFG_CASC_EN = 28;
    localparam int CFG_CASC_OR = 29;
    localparam int CFG_CSTART = 30;
    localparam int CFG_CINIT = 31;

    // ------------------------------------------------------------
    // Reset values and bus answers
    // ------------------------------------------------------------
    localparam logic [31:0] CFG_RST = 32'h0004_0000;
    localparam logic [5:0] SEL_RST = 6'h00;
    localparam logic [3:0] IN_RST = 4'h0;
    localparam logic [3:0] GLB_RST = 4'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Storage element behaviour
    typedef enum logic [1:0] {
        LCC_FF_D = 2'b00,
        LCC_FF_T = 2'b01,
        LCC_FF_JK = 2'b10,
        LCC_FF_SR = 2'b11
    } lcc_ff_e;

    // Pick one control source out of four candidates
    function automatic logic lcc_pick(input logic [1:0] sel,
                                      input logic [3:0] cand);
        return cand[sel];
    endfunction : lcc_pick

endpackage : lcc_pkg

// ==== lcc_top.sv ====
// Row of logic cell clusters with carry and cascade chains, AXI4-Lite
//
// Behaviour
// - Each cell flip-flop works as D, T, JK or SR as configured.
// - Clock, clear and preset each come from global, pin or cell signals.
// - A combinational cell bypasses its flip-flop to the cell output.
// - Local and row outputs each pick table or register on their own.
// - Carry-in feeds both the table and the next carry stage.
// - Carry chains link all cells in a cluster; cascade links all cells in and across clusters.
// - A carry chain longer than a cluster continues in further clusters.
// - Cluster-to-cluster carry skips one cluster, even to even, odd to odd.
// - No carry crosses the memory block in the middle of the row.
// - An n-bit adder uses n+1 cells; n of them each form sum and carry-out.
// - The final carry-out lands in an extra cell as an ordinary signal.
// - An adder cell either bypasses its register or registers the sum.
// - A cluster holds eight cells that may all drive the row at once.
`timescale 1ns/10ps
module lcc_top (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins and routing
    input wire logic [1:0] gp_in,
    output logic [47:0] row_out,
    output logic [47:0] local_out,
    output logic [5:0] chain_end
);

    localparam int N = lcc_pkg::NUM_CELLS;
    localparam int C = lcc_pkg::CELLS_PER_CLU;

    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [7:0] awaddr_r;
    logic aw_have_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic w_have_r;
    logic wr_go;
    logic [5:0] wa;
    logic [5:0] sel_r;
    logic sel_ok;
    logic [3:0] glb_r;
    logic [1:0] gp_meta_r;
    logic [1:0] gp_sync_r;
    logic [31:0] cfg_mem_r [N];
    logic [3:0] in_mem_r [N];
    logic [31:0] rd_nxt;
    logic [47:0] row_r;
    logic [47:0] loc_r;
    logic [5:0] chain_r;
    logic [N-1:0] cin_w;
    logic [N-1:0] cout_w;
    logic [N-1:0] casc_w;
    logic [N-1:0] lut_w;
    logic [N-1:0] q_w;
    logic [N-1:0] loc_w;
    logic [N-1:0] row_w;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Merge write data into an old word under the byte strobes
    function automatic logic [31:0] lcc_merge(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int k = 0; k < 4; k++) begin
            if (strb[k]) begin
                res[8*k +: 8] = nw[8*k +: 8];
            end
        end
        return res;
    endfunction : lcc_merge

    // True when a word address hits a register
    function automatic logic lcc_mapped(input logic [5:0] a);
        return a <= lcc_pkg::ADDR_CHAIN[7:2];
    endfunction : lcc_mapped

    // ------------------------------------------------------------
    // AXI4-Lite write channels
    // ------------------------------------------------------------
    assign wr_go = aw_have_r && w_have_r && !bvalid_r;
    assign wa = awaddr_r[7:2];
    assign sel_ok = sel_r < 6'(N);

    // Address and data are taken in either order, then answered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            aw_have_r <= 1'b0;
            awaddr_r <= 8'h00;
        end else if (s_axi_awvalid && awready_r) begin
            awready_r <= 1'b0;
            aw_have_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_have_r <= 1'b0;
        end else if (bvalid_r && s_axi_bready) begin
            awready_r <= 1'b1;
        end
    end

    // Write data holding slot
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_r <= 1'b1;
            w_have_r <= 1'b0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else if (s_axi_wvalid && wready_r) begin
            wready_r <= 1'b0;
            w_have_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end else if (wr_go) begin
            w_have_r <= 1'b0;
        end else if (bvalid_r && s_axi_bready) begin
            wready_r <= 1'b1;
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= lcc_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= lcc_mapped(wa) ? lcc_pkg::RESP_OKAY
                                      : lcc_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Cell select and global control lines
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_r <= lcc_pkg::SEL_RST;
            glb_r <= lcc_pkg::GLB_RST;
        end else if (wr_go && wa == lcc_pkg::ADDR_SEL[7:2]) begin
            sel_r <= 6'(lcc_merge({26'h0, sel_r}, wdata_r, wstrb_r));
        end else if (wr_go && wa == lcc_pkg::ADDR_GLB[7:2]) begin
            glb_r <= 4'(lcc_merge({28'h0, glb_r}, wdata_r, wstrb_r));
        end
    end

    // Per-cell configuration and data storage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < N; i++) begin
                cfg_mem_r[i] <= lcc_pkg::CFG_RST;
                in_mem_r[i] <= lcc_pkg::IN_RST;
            end
        end else if (wr_go && sel_ok) begin
            if (wa == lcc_pkg::ADDR_CFG[7:2]) begin
                cfg_mem_r[sel_r] <= lcc_merge(cfg_mem_r[sel_r], wdata_r,
                                              wstrb_r);
            end else if (wa == lcc_pkg::ADDR_IN[7:2]) begin
                in_mem_r[sel_r] <= 4'(lcc_merge({28'h0, in_mem_r[sel_r]},
                                                wdata_r, wstrb_r));
            end
        end
    end

    // Two-stage synchroniser for the general-purpose pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gp_meta_r <= 2'h0;
            gp_sync_r <= 2'h0;
        end else begin
            gp_meta_r <= gp_in;
            gp_sync_r <= gp_meta_r;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channels
    // ------------------------------------------------------------
    // Read word decode
    always_comb begin
        logic [5:0] ra;
        ra = s_axi_araddr[7:2];
        rd_nxt = 32'h0000_0000;
        if (ra == lcc_pkg::ADDR_SEL[7:2]) begin
            rd_nxt = {26'h0, sel_r};
        end else if (ra == lcc_pkg::ADDR_CFG[7:2]) begin
            rd_nxt = sel_ok ? cfg_mem_r[sel_r] : 32'h0000_0000;
        end else if (ra == lcc_pkg::ADDR_IN[7:2]) begin
            rd_nxt = sel_ok ? {28'h0, in_mem_r[sel_r]} : 32'h0000_0000;
        end else if (ra == lcc_pkg::ADDR_STAT[7:2]) begin
            if (sel_ok) begin
                rd_nxt = {26'h0, casc_w[sel_r], cout_w[sel_r], q_w[sel_r],
                          row_w[sel_r], loc_w[sel_r], lut_w[sel_r]};
            end
        end else if (ra == lcc_pkg::ADDR_GLB[7:2]) begin
            rd_nxt = {28'h0, glb_r};
        end else if (ra == lcc_pkg::ADDR_ROW_LO[7:2]) begin
            rd_nxt = row_r[31:0];
        end else if (ra == lcc_pkg::ADDR_ROW_HI[7:2]) begin
            rd_nxt = {16'h0, row_r[47:32]};
        end else if (ra == lcc_pkg::ADDR_LOC_LO[7:2]) begin
            rd_nxt = loc_r[31:0];
        end else if (ra == lcc_pkg::ADDR_LOC_HI[7:2]) begin
            rd_nxt = {16'h0, loc_r[47:32]};
        end else if (ra == lcc_pkg::ADDR_CHAIN[7:2]) begin
            rd_nxt = {26'h0, chain_r};
        end
    end

    // Read address taken, data answered on the next edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= lcc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_nxt;
            rresp_r <= lcc_mapped(s_axi_araddr[7:2]) ? lcc_pkg::RESP_OKAY
                                                      : lcc_pkg::RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // ------------------------------------------------------------
    // Cell array and chain wiring
    // ------------------------------------------------------------
    for (genvar i = 0; i < N; i++) begin : g_cell
        localparam int POS = i % C;
        localparam int CLU = i / C;
        logic link;
        logic nbr;
        if (POS != 0) begin : g_near
            assign link = cout_w[i-1];
        end else if (CLU >= 2 && !(CLU - 2 <= lcc_pkg::MEM_AFTER &&
                     CLU > lcc_pkg::MEM_AFTER)) begin : g_skip
            assign link = cout_w[i-C-1];
        end else begin : g_none
            assign link = 1'b0;
        end
        // A chain start injects its own carry instead of the link
        assign cin_w[i] = cfg_mem_r[i][lcc_pkg::CFG_CSTART] ?
                          cfg_mem_r[i][lcc_pkg::CFG_CINIT] : link;
        assign nbr = loc_w[(i + N - 1) % N];
        lcc_cell u_cell (
            .aclk(aclk),
            .aresetn(aresetn),
            .cfg(cfg_mem_r[i]),
            .din(in_mem_r[i]),
            .cin(cin_w[i]),
            .casc_in(i == 0 ? 1'b0 : casc_w[(i + N - 1) % N]),
            .cout(cout_w[i]),
            .casc_out(casc_w[i]),
            .clk_src({nbr, gp_sync_r[0], glb_r[1], glb_r[0]}),
            .clr_src({nbr, gp_sync_r[1], glb_r[2], 1'b0}),
            .pre_src({nbr, gp_sync_r[1], glb_r[3], 1'b0}),
            .lut_out(lut_w[i]),
            .q(q_w[i]),
            .local_out(loc_w[i]),
            .row_out(row_w[i])
        );
    end

    // Every cell drives the row at once; last carry of each cluster
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            row_r <= 48'h0000_0000_0000;
            loc_r <= 48'h0000_0000_0000;
            chain_r <= 6'h00;
        end else begin
            row_r <= row_w;
            loc_r <= loc_w;
            for (int k = 0; k < lcc_pkg::NUM_CLU; k++) begin
                chain_r[k] <= cout_w[k*C + C - 1];
            end
        end
    end

    assign row_out = row_r;
    assign local_out = loc_r;
    assign chain_end = chain_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_skip_link: assert property (!cfg_mem_r[16][lcc_pkg::CFG_CSTART]
        |-> cin_w[16] == cout_w[7])
        else $error("cluster 2 did not take carry from cluster 0");
    a_mem_stop: assert property (!cfg_mem_r[24][lcc_pkg::CFG_CSTART]
        |-> !cin_w[24])
        else $error("carry crossed the memory block");
    a_in_cluster: assert property (!cfg_mem_r[9][lcc_pkg::CFG_CSTART]
        |-> cin_w[9] == cout_w[8])
        else $error("carry broken inside a cluster");
    a_row_follow: assert property (##1 row_out == $past(row_w))
        else $error("row output lost a cell value");
    a_write_resp: assert property (wr_go |=> s_axi_bvalid ##0
        (s_axi_bresp == lcc_pkg::RESP_OKAY) == $past(lcc_mapped(wa)))
        else $error("write answer missing or wrong");
    a_read_hold: assert property ((s_axi_rvalid && !s_axi_rready)
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");

    c_write_done: cover property (s_axi_bvalid && s_axi_bready);
    c_read_done: cover property (s_axi_rvalid && s_axi_rready);
    c_chain_carry: cover property (chain_end[0] && cin_w[16]);

endmodule : lcc_top

// ==== tb_top.sv ====
// Self-checking bench for the logic cell row with carry chain
`timescale 1ns/10ps
module tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, gp_in;
    logic [31:0] rdata;
    logic [47:0] row_out, local_out;
    logic [5:0] chain_end;
    logic [33:0] exp_q[$];
    int n_errors = 0;
    int samples_checked = 0;
    logic [7:0] a, b;
    logic [8:0] s;
    logic [15:0] m;
    logic [3:0] d;
    logic l;

    lcc_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(1'b1), .gp_in(gp_in), .row_out(row_out),
        .local_out(local_out), .chain_end(chain_end));
    lcc_fabric fab (.aclk(aclk), .gp_in(gp_in));

    // Clock at 40 MHz
    always #12.5 aclk = ~aclk;

    task automatic chk(input string nm, input logic [33:0] ex, sn);
        samples_checked++;
        if (sn !== ex) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, ex, sn);
        end
    endtask : chk

    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    // Write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] ad, input logic [31:0] dt,
                      input logic [1:0] rsp);
        exp_q.push_back({rsp, 32'h0});
        awaddr <= ad;
        wdata <= dt;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (awvalid || wvalid);
        do @(posedge aclk); while (!bvalid);
    endtask : wr

    // Read: the expected response and data are noted first
    task automatic rd(input logic [7:0] ad, input logic [33:0] ex);
        exp_q.push_back(ex);
        araddr <= ad;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
    endtask : rd

    // Monitor takes the oldest note at each response handshake
    always @(posedge aclk) begin
        if (bvalid) chk("bresp", exp_q.pop_front(), {bresp, 32'h0});
        if (rvalid) chk("rdata", exp_q.pop_front(), {rresp, rdata});
    end

    // Watchdog cuts a hung run short
    initial begin
        repeat (5000) @(posedge aclk);
        n_errors++;
        end_of_test();
    end

    // Main sequence
    initial begin
        void'($urandom(32'hCC065469));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(lcc_pkg::ADDR_CFG, {2'h0, lcc_pkg::CFG_RST});
        rd(8'h28, {lcc_pkg::RESP_SLVERR, 32'h0});
        wr(8'h28, 32'hFFFF_FFFF, lcc_pkg::RESP_SLVERR);
        $display("test reset done");
        // Combinational cell with cascade AND, then OR
        wr(lcc_pkg::ADDR_SEL, 32'h5, 2'h0);
        for (int i = 0; i < 4; i++) begin
            m = 16'($urandom);
            d = 4'($urandom);
            l = m[d];
            wr(lcc_pkg::ADDR_CFG,
               {2'b00, i[0], 1'b1, 9'h000, 1'b1, 2'b00, m}, 2'h0);
            wr(lcc_pkg::ADDR_IN, {28'h0, d}, 2'h0);
            rd(lcc_pkg::ADDR_STAT,
               {28'h0, i[0] & l, 2'b00, {3{i[0] & l}}});
        end
        $display("test combinational done");
        // Register on local output, table on row output
        wr(lcc_pkg::ADDR_CFG, 32'h0008_FFFF, 2'h0);
        rd(lcc_pkg::ADDR_STAT, 34'h25);
        wr(lcc_pkg::ADDR_GLB, 32'h1, 2'h0);
        wr(lcc_pkg::ADDR_GLB, 32'h0, 2'h0);
        rd(lcc_pkg::ADDR_STAT, 34'h2F);
        wr(lcc_pkg::ADDR_CFG, 32'h1008_0000, 2'h0);
        rd(lcc_pkg::ADDR_STAT, 34'h0A);
        wr(lcc_pkg::ADDR_CFG, 32'h0009_FFFF, 2'h0);
        wr(lcc_pkg::ADDR_GLB, 32'h1, 2'h0);
        rd(lcc_pkg::ADDR_STAT, 34'h25);
        $display("test register done");
        // Preset then clear from the global lines, clear wins
        wr(lcc_pkg::ADDR_CFG, 32'h0508_0000, 2'h0);
        wr(lcc_pkg::ADDR_GLB, 32'h9, 2'h0);
        rd(lcc_pkg::ADDR_STAT, 34'h0A);
        rd(lcc_pkg::ADDR_LOC_LO, 34'h20);
        wr(lcc_pkg::ADDR_GLB, 32'hD, 2'h0);
        rd(lcc_pkg::ADDR_STAT, 34'h00);
        $display("test clear preset done");
        // Eight-bit adder in cluster 0, carry lands in cell 16
        a = 8'($urandom);
        b = 8'($urandom);
        s = a + b;
        for (int i = 0; i < 8; i++) begin
            wr(lcc_pkg::ADDR_SEL, 32'(i), 2'h0);
            wr(lcc_pkg::ADDR_CFG, {1'b0, i == 0, 30'h0024_E896}, 2'h0);
            wr(lcc_pkg::ADDR_IN, {30'h0, b[i], a[i]}, 2'h0);
        end
        wr(lcc_pkg::ADDR_SEL, 32'd16, 2'h0);
        wr(lcc_pkg::ADDR_CFG, 32'h0024_00F0, 2'h0);
        wr(lcc_pkg::ADDR_SEL, 32'd15, 2'h0);
        wr(lcc_pkg::ADDR_CFG, 32'hC024_FF00, 2'h0);
        rd(lcc_pkg::ADDR_ROW_LO,
           {17'h0, s[8], 8'h00, s[7:0]});
        rd(lcc_pkg::ADDR_CHAIN,
           {28'h0, 5'h01, s[8]});
        $display("test carry done");
        end_of_test();
    end
endmodule : tb_top
